// ---- hw/psb_pkg.sv ----
// constants, map layout and state codes for the module sideband block
package psb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;        // system clock period
  localparam int unsigned RESET_MIN_NS  = 10000;     // least reset pulse, ns
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_NS       = 2000000;   // management init time, ns
  localparam int unsigned INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_W         = 16;        // reset filter counter width
  localparam int          INIT_W        = 18;        // init counter width
  localparam int          NUM_CHAN      = 8;         // channel count
  localparam logic [6:0]  DEV_ADDR      = 7'h50;     // serial bus device address
  localparam logic [7:0]  ID_VALUE      = 8'h5a;     // identity byte, value arbitrary
  localparam logic [3:0]  BYTE_BITS     = 4'h8;      // bits per byte
  localparam logic [3:0]  LAST_BIT      = 4'h7;      // last data bit index
  // map byte indices
  localparam logic [2:0]  MAP_STATUS    = 3'h0;      // status, read clears done flag
  localparam logic [2:0]  MAP_CONTROL   = 3'h1;      // power control
  localparam logic [2:0]  MAP_CHAN_OFF  = 3'h2;      // channel shutdown mask
  localparam logic [2:0]  MAP_FAULT_LAT = 3'h3;      // latched faults, clear on read
  localparam logic [2:0]  MAP_FAULT_NOW = 3'h4;      // live faults
  localparam logic [2:0]  MAP_ID        = 3'h5;      // identity byte
  // field positions
  localparam int          ST_NOT_READY  = 0;         // status: data not ready
  localparam int          ST_DONE       = 1;         // status: reset-done flag
  localparam int          ST_INIT_SW    = 2;         // status: software init mode
  localparam int          ST_HIGH_PWR   = 3;         // status: high power state
  localparam int          CTL_HP_EN     = 0;         // control: enable high power
  // reset values
  localparam logic [7:0]  CONTROL_RST   = 8'h00;     // control default
  localparam logic [7:0]  CHAN_OFF_RST  = 8'h00;     // all channels on
  typedef enum logic [6:0] {
    PSB_IDLE  = 7'h01,                                // waiting for start
    PSB_ADDR  = 7'h02,                                // shifting address byte
    PSB_AACK  = 7'h04,                                // address acknowledge
    PSB_WDATA = 7'h08,                                // shifting write byte
    PSB_WACK  = 7'h10,                                // write acknowledge
    PSB_READ  = 7'h20,                                // driving read byte
    PSB_RACK  = 7'h40                                 // host acknowledge slot
  } psb_bus_st_t;
endpackage

// ---- hw/psb_sync2.sv ----
// two flip-flop synchroniser for one pin level
module psb_sync2 (
  input  wire logic clk_sys_i,  // system clock
  input  wire logic reset_i,    // synchronous reset, active high
  input  wire logic rst_val_i,  // idle level loaded in reset, tied by parent
  input  wire logic d_i,        // asynchronous level
  output logic      q_o         // synchronised level
);
  typedef struct packed {
    logic meta;                 // first stage, read only by second stage
    logic q;                    // second stage
  } psb_sync_t;
  psb_sync_t r_reg;             // state
  psb_sync_t r_next;            // next state

  // shift the level through both stages
  always_comb begin
    r_next.meta = d_i;
    r_next.q    = r_reg.meta;
  end

  // reset to the idle level given by the parent as a constant
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r_reg <= {rst_val_i, rst_val_i};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.q;
endmodule

// ---- hw/psb_sideband.sv ----
// module-side low-speed sideband: select, reset, init mode, present, attention, serial map
module psb_sideband #(
  parameter int unsigned RESET_MIN_CYCLES = psb_pkg::RESET_MIN_CYC, // least reset low
  parameter int unsigned INIT_CYCLES      = psb_pkg::INIT_CYC       // init duration
) (
  input  wire logic                          clk_sys_i,            // 100 MHz clock
  input  wire logic                          reset_i,              // power-up reset
  input  wire logic                          module_select_n_i,    // select pin, low active
  input  wire logic                          module_reset_n_i,     // reset pin, low active
  input  wire logic                          init_control_select_i,// init mode pin level
  input  wire logic                          init_control_driven_i,// host drives init pin
  input  wire logic                          scl_i,                // serial clock pin
  input  wire logic                          sda_i,                // serial data pin in
  output logic                               sda_o,                // serial data out, low
  output logic                               sda_oe_o,             // serial data pull low
  input  wire logic [psb_pkg::NUM_CHAN-1:0]  fault_i,              // internal fault levels
  output logic                               attention_n_o,        // attention out level
  output logic                               attention_oe_o,       // attention sinks
  output logic                               module_present_n_o,   // present out level
  output logic                               module_present_oe_o,  // present sinks
  output logic                               high_power_o,         // high power state
  output logic                               not_ready_o,          // init in progress
  output logic [psb_pkg::NUM_CHAN-1:0]       chan_shutdown_o       // channel off mask
);
  typedef struct packed {
    psb_pkg::psb_bus_st_t         st;        // serial bus state
    logic [3:0]                   bitcnt;    // bit counter
    logic [7:0]                   shreg;     // byte shifter
    logic                         rw;        // read transfer
    logic                         ptr_set;   // pointer byte already taken
    logic                         acked;     // host acked last read byte
    logic [2:0]                   ptr;       // map pointer
    logic                         sda_low;   // pulling data low
    logic                         scl_d;     // previous clock sample
    logic                         sda_d;     // previous data sample
    logic [psb_pkg::RST_W-1:0]    rst_cnt;   // reset low time
    logic                         pin_rst;   // qualified pin reset
    logic [psb_pkg::INIT_W-1:0]   init_cnt;  // init timer
    logic                         not_ready; // management not ready
    logic                         done;      // reset-done flag
    logic                         hp_en;     // software high power enable
    logic [psb_pkg::NUM_CHAN-1:0] chan_off;  // shutdown mask
    logic [psb_pkg::NUM_CHAN-1:0] flt_lat;   // latched faults
    logic [psb_pkg::NUM_CHAN-1:0] flt_d;     // previous faults
    logic                         high_pwr;  // power state
    logic                         attn;      // attention driven
    logic                         present;   // present driven
  } psb_state_t;

  psb_state_t r_reg;   // state
  psb_state_t r_next;  // next state
  logic       sel_n_s; // synced select
  logic       rst_n_s; // synced reset pin
  logic       init_s;  // synced init mode, 1 = software
  logic       scl_s;   // synced serial clock
  logic       sda_s;   // synced serial data
  logic       init_pad;// pad level with pull-up
  logic       wr_chan; // channel mask written this cycle

  // internal pull-up: a floating pin reads high
  assign init_pad = init_control_driven_i ? init_control_select_i : 1'b1;

  psb_sync2 u_sel  (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_val_i(1'b1),
                    .d_i(module_select_n_i), .q_o(sel_n_s));
  psb_sync2 u_rst  (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_val_i(1'b1),
                    .d_i(module_reset_n_i), .q_o(rst_n_s));
  psb_sync2 u_init (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_val_i(1'b1),
                    .d_i(init_pad), .q_o(init_s));
  psb_sync2 u_scl  (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_val_i(1'b1),
                    .d_i(scl_i), .q_o(scl_s));
  psb_sync2 u_sda  (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_val_i(1'b1),
                    .d_i(sda_i), .q_o(sda_s));

  // map read mux, pointer is three bits so upper bytes read as zero
  function automatic logic [7:0] map_rd(input psb_state_t s, input logic isw);
    logic [7:0] v;
    v = 8'h00;
    case (s.ptr)
      psb_pkg::MAP_STATUS: begin
        v[psb_pkg::ST_NOT_READY] = s.not_ready;
        v[psb_pkg::ST_DONE]      = s.done;
        v[psb_pkg::ST_INIT_SW]   = isw;
        v[psb_pkg::ST_HIGH_PWR]  = s.high_pwr;
      end
      psb_pkg::MAP_CONTROL:   v[psb_pkg::CTL_HP_EN] = s.hp_en;
      psb_pkg::MAP_CHAN_OFF:  v = s.chan_off;
      psb_pkg::MAP_FAULT_LAT: v = s.flt_lat;
      psb_pkg::MAP_FAULT_NOW: v = s.flt_d;
      psb_pkg::MAP_ID:        v = psb_pkg::ID_VALUE;
      default:                v = 8'h00;
    endcase
    return v;
  endfunction

  // all next-state logic
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic rd_load;
    logic [psb_pkg::NUM_CHAN-1:0] flt_rise;
    logic [7:0] rd_byte;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    rd_load  = 1'b0;
    flt_rise = '0;
    rd_byte  = 8'h00;
    wr_chan  = 1'b0;
    r_next   = r_reg;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    r_next.flt_d = fault_i;
    scl_rise = scl_s & ~r_reg.scl_d;
    scl_fall = ~scl_s & r_reg.scl_d;
    start    = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
    stop     = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
    flt_rise = fault_i & ~r_reg.flt_d;
    rd_byte  = map_rd(r_reg, init_s);

    // serial bus slave, only while selected
    if (sel_n_s) begin
      r_next.st      = psb_pkg::PSB_IDLE;   // deselected: ignore and release
      r_next.sda_low = 1'b0;
    end else if (start) begin
      r_next.st      = psb_pkg::PSB_ADDR;
      r_next.bitcnt  = 4'h0;
      r_next.sda_low = 1'b0;
    end else if (stop) begin
      r_next.st      = psb_pkg::PSB_IDLE;
      r_next.sda_low = 1'b0;
    end else if (scl_rise) begin
      case (r_reg.st)
        psb_pkg::PSB_ADDR, psb_pkg::PSB_WDATA: begin
          r_next.shreg  = {r_reg.shreg[6:0], sda_s};
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end
        psb_pkg::PSB_RACK: r_next.acked = ~sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (r_reg.st)
        psb_pkg::PSB_ADDR: begin
          if (r_reg.bitcnt == psb_pkg::BYTE_BITS) begin
            if (r_reg.shreg[7:1] == psb_pkg::DEV_ADDR) begin
              r_next.st      = psb_pkg::PSB_AACK;
              r_next.rw      = r_reg.shreg[0];
              r_next.sda_low = 1'b1;
            end else begin
              r_next.st = psb_pkg::PSB_IDLE;  // other address: stay off the bus
            end
          end
        end
        psb_pkg::PSB_AACK: begin
          r_next.bitcnt = 4'h0;
          if (r_reg.rw) begin
            rd_load = 1'b1;
          end else begin
            r_next.st      = psb_pkg::PSB_WDATA;
            r_next.ptr_set = 1'b0;
            r_next.sda_low = 1'b0;
          end
        end
        psb_pkg::PSB_WDATA: begin
          if (r_reg.bitcnt == psb_pkg::BYTE_BITS) begin
            r_next.st      = psb_pkg::PSB_WACK;
            r_next.sda_low = 1'b1;
            if (!r_reg.ptr_set) begin
              r_next.ptr     = r_reg.shreg[2:0];
              r_next.ptr_set = 1'b1;
            end else begin
              r_next.ptr = r_reg.ptr + 3'h1;
              if (r_reg.ptr == psb_pkg::MAP_CONTROL) begin
                r_next.hp_en = r_reg.shreg[psb_pkg::CTL_HP_EN];
              end
              if (r_reg.ptr == psb_pkg::MAP_CHAN_OFF) begin
                r_next.chan_off = r_reg.shreg;
                wr_chan         = 1'b1;
              end
            end
          end
        end
        psb_pkg::PSB_WACK: begin
          r_next.st      = psb_pkg::PSB_WDATA;
          r_next.bitcnt  = 4'h0;
          r_next.sda_low = 1'b0;
        end
        psb_pkg::PSB_READ: begin
          if (r_reg.bitcnt == psb_pkg::LAST_BIT) begin
            r_next.st      = psb_pkg::PSB_RACK;
            r_next.sda_low = 1'b0;
            r_next.ptr     = r_reg.ptr + 3'h1;
          end else begin
            r_next.bitcnt  = r_reg.bitcnt + 4'h1;
            r_next.shreg   = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_low = ~r_reg.shreg[6];
          end
        end
        psb_pkg::PSB_RACK: begin
          r_next.bitcnt = 4'h0;
          if (r_reg.acked) begin
            rd_load = 1'b1;
          end else begin
            r_next.st = psb_pkg::PSB_IDLE;      // host nacked: wait for stop
          end
        end
        default: r_next.st = psb_pkg::PSB_IDLE;
      endcase
    end

    // load a read byte and apply read side effects; a new event wins
    if (rd_load) begin
      r_next.st      = psb_pkg::PSB_READ;
      r_next.shreg   = rd_byte;
      r_next.sda_low = ~rd_byte[7];
      if (r_reg.ptr == psb_pkg::MAP_STATUS) begin
        r_next.done = 1'b0;
      end
      if (r_reg.ptr == psb_pkg::MAP_FAULT_LAT) begin
        r_next.flt_lat = '0;
      end
    end
    r_next.flt_lat = r_next.flt_lat | flt_rise; // set beats clear-on-read

    // init timer; completion posts the reset-done flag
    if (r_reg.not_ready) begin
      if (r_reg.init_cnt >= psb_pkg::INIT_W'(INIT_CYCLES - 1)) begin
        r_next.not_ready = 1'b0;
        r_next.done      = 1'b1;
      end else begin
        r_next.init_cnt = r_reg.init_cnt + psb_pkg::INIT_W'(1);
      end
    end

    // power state: software mode waits for enable, hardware mode goes
    r_next.high_pwr = ~r_reg.not_ready & (~init_s | r_reg.hp_en);

    // attention sinks for a fault or reset done, else floats
    r_next.attn    = r_reg.done | (|r_reg.flt_lat);
    r_next.present = 1'b1;

    // reset pin filter: short low pulses never reach the logic
    if (!rst_n_s) begin
      if (r_reg.rst_cnt >= psb_pkg::RST_W'(RESET_MIN_CYCLES - 1)) begin
        r_next.pin_rst = 1'b1;
      end else begin
        r_next.rst_cnt = r_reg.rst_cnt + psb_pkg::RST_W'(1);
      end
    end else begin
      r_next.rst_cnt = '0;
      r_next.pin_rst = 1'b0;
    end

    // qualified reset: every setting back to default
    if (r_reg.pin_rst) begin
      r_next.st        = psb_pkg::PSB_IDLE;
      r_next.sda_low   = 1'b0;
      r_next.ptr       = 3'h0;
      r_next.init_cnt  = '0;
      r_next.not_ready = 1'b1;
      r_next.done      = 1'b0;
      r_next.hp_en     = psb_pkg::CONTROL_RST[psb_pkg::CTL_HP_EN];
      r_next.chan_off  = psb_pkg::CHAN_OFF_RST;
      r_next.flt_lat   = '0;
      r_next.high_pwr  = 1'b0;
      r_next.attn      = 1'b0;
    end
  end

  // register the state; power-up starts the init timer on its own
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r_reg           <= '0;
      r_reg.st        <= psb_pkg::PSB_IDLE;
      r_reg.scl_d     <= 1'b1;
      r_reg.sda_d     <= 1'b1;
      r_reg.not_ready <= 1'b1;
      r_reg.chan_off  <= psb_pkg::CHAN_OFF_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // open-drain pins drive only low
  assign sda_o               = 1'b0;
  assign sda_oe_o            = r_reg.sda_low;
  assign attention_n_o       = 1'b0;
  assign attention_oe_o      = r_reg.attn;
  assign module_present_n_o  = 1'b0;
  assign module_present_oe_o = r_reg.present;
  assign high_power_o        = r_reg.high_pwr;
  assign not_ready_o         = r_reg.not_ready;
  assign chan_shutdown_o     = r_reg.chan_off;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_floating;
    !init_control_driven_i [*3];
  endsequence
  sequence s_ready_edge;
    $fell(r_reg.not_ready) ##1 1'b1;
  endsequence

  chk_select_gates_bus: assert property (sel_n_s |-> ##1 !sda_oe_o)
    else $error("data driven while deselected");
  chk_reset_pulse_min: assert property ($rose(r_reg.pin_rst) |->
    $past(r_reg.rst_cnt) >= psb_pkg::RST_W'(RESET_MIN_CYCLES - 1))
    else $error("reset taken before minimum pulse");
  chk_reset_defaults: assert property (r_reg.pin_rst |-> ##1
    (chan_shutdown_o == psb_pkg::CHAN_OFF_RST && !r_reg.hp_en && not_ready_o))
    else $error("settings not restored by reset");
  chk_done_attention: assert property (s_ready_edge |-> attention_oe_o)
    else $error("no attention after reset done");
  chk_attention_cause: assert property (attention_oe_o |->
    $past(r_reg.done || (|r_reg.flt_lat)))
    else $error("attention without cause");
  chk_pullup_floating: assert property (s_floating |-> init_s)
    else $error("floating init pin not high");
  chk_sw_low_power: assert property ((init_s && !r_reg.hp_en) |-> ##1 !high_power_o)
    else $error("high power without enable");
  chk_hw_high_power: assert property ((!init_s && !r_reg.not_ready && !r_reg.pin_rst)
    |-> ##1 high_power_o)
    else $error("hardware mode stayed low power");
  // the flop still holds its reset value at the first edge after release
  chk_present_low: assert property (!$past(reset_i) |-> module_present_oe_o)
    else $error("present line released");
  // a qualified pin reset in the same cycle wins over the mask write
  chk_chan_write: assert property ((wr_chan && !r_reg.pin_rst) |-> ##1
    chan_shutdown_o == $past(r_reg.shreg))
    else $error("channel mask not applied");
endmodule

// ---- tb/psb_host_model.sv ----
// host board controller model: two-wire serial master with board pull-up
module psb_host_model (
  input  wire logic clk_sys_i,  // system clock
  input  wire logic sda_oe_i,   // module sinks data line
  output logic      scl_o,      // serial clock, idles high
  output logic      sda_o       // resolved data line level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_low = 1'b0;        // host sinks data line
  initial scl_o = 1'b1;
  // pull-up: line reads high unless some party sinks it
  assign sda_o = ~(host_low | sda_oe_i);
  // one bit: data moves while clock low, sampled mid high, 80 ns period
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk_sys_i) host_low <= ~b;
    repeat (3) @(posedge clk_sys_i);
    scl_o <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    r = sda_o;
    repeat (2) @(posedge clk_sys_i);
    scl_o <= 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic bus_start();
    @(posedge clk_sys_i) host_low <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    host_low <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    scl_o <= 1'b0;
  endtask
  // stop: data rises while clock high, then bus idles released
  task automatic bus_stop();
    @(posedge clk_sys_i) host_low <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    host_low <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  // byte out msb first, then release for the module's ack
  task automatic bus_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // byte in; a nack on the last byte ends the read
  task automatic bus_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ---- tb/psb_sideband_tb_top.sv ----
// self-checking bench for the module sideband block
module psb_sideband_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned INIT_C = 50;  // short init time for sim
  localparam int unsigned RMIN_C = 20;  // short reset minimum for sim
  logic       clk_sys_i = 1'b0;  // 100 MHz clock
  logic       reset_i;           // power-up reset
  logic       sel_n;             // module select, low active
  logic       mrst_n;            // module reset pin
  logic       init_lvl;          // init mode level when driven
  logic       init_drv;          // host drives init pin
  logic       scl, sda, sda_oe;  // serial bus
  logic       sda_lvl;           // level the module puts on the data line
  logic [7:0] fault;             // internal faults
  logic       attn_n, attn_oe, prs_n, prs_oe, hp, nr;
  logic [7:0] mask;              // channel shutdown mask
  logic [7:0] d;                 // read data
  logic       ack;               // write acknowledged
  int         bad_count = 0;     // mismatches
  int         n_checks = 0;      // comparisons
  // host pull-ups on open-drain pins
  wire attn_pin = attn_oe ? attn_n : 1'b1;
  wire prs_pin  = prs_oe ? prs_n : 1'b1;
  always #5 clk_sys_i = ~clk_sys_i;
  psb_sideband #(.RESET_MIN_CYCLES(RMIN_C), .INIT_CYCLES(INIT_C)) i_psb_sideband (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .module_select_n_i(sel_n),
    .module_reset_n_i(mrst_n), .init_control_select_i(init_lvl),
    .init_control_driven_i(init_drv), .scl_i(scl), .sda_i(sda), .sda_o(sda_lvl),
    .sda_oe_o(sda_oe), .fault_i(fault), .attention_n_o(attn_n),
    .attention_oe_o(attn_oe), .module_present_n_o(prs_n),
    .module_present_oe_o(prs_oe), .high_power_o(hp), .not_ready_o(nr),
    .chan_shutdown_o(mask));
  psb_host_model i_psb_host_model (
    .clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  // compare one value and count it
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // map write: address, pointer, one data byte
  task automatic wr_reg(input logic [2:0] idx, input logic [7:0] v, output logic ok);
    logic a1, a2, a3;
    i_psb_host_model.bus_start();
    i_psb_host_model.bus_wr({psb_pkg::DEV_ADDR, 1'b0}, a1);
    i_psb_host_model.bus_wr({5'h00, idx}, a2);
    i_psb_host_model.bus_wr(v, a3);
    i_psb_host_model.bus_stop();
    ok = a1 & a2 & a3;
  endtask
  // map read: set pointer, repeated start, one byte then nack
  task automatic rd_reg(input logic [2:0] idx, output logic [7:0] v);
    logic a;
    i_psb_host_model.bus_start();
    i_psb_host_model.bus_wr({psb_pkg::DEV_ADDR, 1'b0}, a);
    i_psb_host_model.bus_wr({5'h00, idx}, a);
    i_psb_host_model.bus_start();
    i_psb_host_model.bus_wr({psb_pkg::DEV_ADDR, 1'b1}, a);
    i_psb_host_model.bus_rd(1'b1, v);
    i_psb_host_model.bus_stop();
  endtask
  // counts, verdict, end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a tenth of this
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    bad_count++;
    end_of_test();
  end
  // main sequence; init pin left floating so the pull-up picks software mode
  initial begin
    reset_i = 1'b1;
    sel_n = 1'b1;
    mrst_n = 1'b1;
    init_lvl = 1'b0;
    init_drv = 1'b0;
    fault = 8'h00;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    check("present", prs_pin, 8'h00);
    check("not_ready", nr, 8'h01);
    check("sda level", sda_lvl, 8'h00);
    repeat (INIT_C + 6) @(posedge clk_sys_i);
    check("attention", attn_pin, 8'h00);
    check("high_power", hp, 8'h00);
    sel_n <= 1'b0;  // only this module's select is ever lowered
    rd_reg(psb_pkg::MAP_STATUS, d);  // cause of attention read over the bus
    check("status", d, 8'h06);
    check("attention", attn_pin, 8'h01);
    $display("test power_up done");
    wr_reg(psb_pkg::MAP_CHAN_OFF, 8'h0f, ack);
    check("wr ack", ack, 8'h01);
    check("mask", mask, 8'h0f);
    rd_reg(psb_pkg::MAP_CHAN_OFF, d);
    check("mask rd", d, 8'h0f);
    rd_reg(psb_pkg::MAP_ID, d);
    check("id", d, psb_pkg::ID_VALUE);
    rd_reg(3'h6, d);
    check("unmapped", d, 8'h00);
    sel_n <= 1'b1;
    wr_reg(psb_pkg::MAP_CHAN_OFF, 8'hf0, ack);
    check("unsel ack", ack, 8'h00);
    check("unsel mask", mask, 8'h0f);
    sel_n <= 1'b0;
    i_psb_host_model.bus_start();
    i_psb_host_model.bus_wr(8'h42, ack);
    i_psb_host_model.bus_stop();
    check("other addr", ack, 8'h00);
    $display("test select done");
    wr_reg(psb_pkg::MAP_CONTROL, 8'h01, ack);
    check("high_power", hp, 8'h01);
    fault <= 8'h04;
    repeat (4) @(posedge clk_sys_i);
    check("fault attn", attn_pin, 8'h00);
    rd_reg(psb_pkg::MAP_FAULT_NOW, d);
    check("fault now", d, 8'h04);
    fault <= 8'h00;
    rd_reg(psb_pkg::MAP_FAULT_LAT, d);
    check("fault lat", d, 8'h04);
    rd_reg(psb_pkg::MAP_FAULT_LAT, d);
    check("fault clr", d, 8'h00);
    check("attn off", attn_pin, 8'h01);
    $display("test fault done");
    mrst_n <= 1'b0;
    repeat (RMIN_C / 2) @(posedge clk_sys_i);
    mrst_n <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    check("short rst", mask, 8'h0f);
    mrst_n <= 1'b0;
    repeat (RMIN_C + 10) @(posedge clk_sys_i);
    check("rst mask", mask, 8'h00);
    check("rst hp", hp, 8'h00);
    check("rst nr", nr, 8'h01);
    mrst_n <= 1'b1;
    repeat (INIT_C + 20) @(posedge clk_sys_i);
    check("rst attn", attn_pin, 8'h00);
    rd_reg(psb_pkg::MAP_STATUS, d);  // status only trusted after done
    check("rst status", d, 8'h06);
    $display("test reset_pin done");
    reset_i <= 1'b1;  // re-insertion with init pin driven low, held
    init_drv <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (INIT_C + 10) @(posedge clk_sys_i);
    check("hw hp", hp, 8'h01);
    rd_reg(psb_pkg::MAP_STATUS, d);
    check("hw status", d, 8'h0a);
    $display("test hw_init done");
    end_of_test();
  end
endmodule
